// ===== hw/rpf_sync.sv
// Purpose: two-flop synchroniser for one comparator level
// Assumes: input asynchronous to clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module rpf_sync
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      // reset to the in-regulation level, else a false fault follows reset
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : rpf_sync
`default_nettype wire

// ===== hw/rpf_top.sv
// Purpose: power-good latch, fault masking, warning count and interrupt pin
// Assumes: read strobes and warning ticks are synchronous one-cycle pulses
// Notes: pairing, remote sense, frequency and OV threshold come from straps
// Behaviour
// - power-good status drops to 0 when output falls below threshold
// - each regulator has an unmask bit; 0 masks, 1 enables the fault
// - unmasked fault drives the active-low interrupt pin low
// - interrupt holds until regulator off, or recovered and bit read
// - status stays latched at 0 until regulator off, or a host read completes after recovery
// - live power-good is routed to power_good_live only; status carries the latched value
// - paired converters switch out of phase
// - pair settings come from converter one and converter three
// - pairing is factory fixed, not changeable by register writes
// - remote-sense select is factory fixed; 1 turns inputs two, four to sense
// - buck-boost frequency is factory fixed to one of two options
// - buck-boost overvoltage threshold is factory fixed to one of two
// - sixteen consecutive 75% cycles set warning flag and unmasked irq
`timescale 1ns/1ps
`default_nettype none
module rpf_top
  import rpf_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [5:0]   pgood_comp_in,
  input  wire logic [5:0]   regulator_on,
  input  wire logic [5:0]   fault_unmask_bit,
  input  wire logic [5:0]   status_read,
  input  wire logic         sw_cycle_tick,
  input  wire logic         peak_over_warn,
  input  wire logic         current_warning_mask,
  input  wire logic         warning_read,
  input  wire logic         strap_dual_12,
  input  wire logic         strap_dual_34,
  input  wire logic         strap_remote_sense,
  input  wire logic         strap_bb_freq,
  input  wire logic         strap_bb_ov,
  input  wire logic [7:0]   vset_reg [0:3],
  output logic [5:0]        power_good_status,
  output logic [5:0]        power_good_live,
  output logic              interrupt_out_low,
  output logic              current_warning_flag,
  output logic              dual_12,
  output logic              dual_34,
  output logic              remote_sense_select,
  output logic              feedback_two_is_gnd,
  output logic              feedback_four_is_gnd,
  output logic              bb_freq_high,
  output logic              bb_ov_high,
  output logic [3:0]        phase_invert,
  output logic [7:0]        vset_eff [0:3]
);
  rpf_vec_t pg_sync;
  rpf_vec_t stat_q, stat_d;
  rpf_vec_t flt_q, flt_d;
  logic [`RPF_WARN_CNT_W-1:0] wcnt_q, wcnt_d;
  logic warn_q, warn_d;
  logic irq_q, irq_d;
  logic [4:0] strap_q, strap_d;
  logic strap_done_q, strap_done_d;

  genvar gi;
  generate
    for (gi = 0; gi < `RPF_NUM_REG; gi++)
    begin : g_sync
      rpf_sync u_sync
      (
        .clk      (clk),
        .reset    (reset),
        .async_in (pgood_comp_in[gi]),
        .sync_out (pg_sync[gi])
      );
    end
  endgenerate

  // off regulator reads good and clears its fault
  always_comb
  begin
    for (int i = 0; i < `RPF_NUM_REG; i++)
    begin
      stat_d[i] = stat_q[i];
      flt_d[i]  = flt_q[i];
      if (!regulator_on[i])
      begin
        stat_d[i] = 1'b1;
        flt_d[i]  = 1'b0;
      end
      else if (!pg_sync[i])
      begin
        stat_d[i] = 1'b0;
        flt_d[i]  = 1'b1;   // set wins over a read
      end
      else if (status_read[i])
      begin
        stat_d[i] = 1'b1;
        flt_d[i]  = 1'b0;
      end
    end
  end

  // warning run counter; a cycle below 75% restarts the run
  always_comb
  begin
    wcnt_d = wcnt_q;
    warn_d = warn_q;
    if (sw_cycle_tick)
    begin
      if (!peak_over_warn)
        wcnt_d = '0;
      else if (wcnt_q != `RPF_WARN_CNT_W'(`RPF_WARN_RUN))
        wcnt_d = wcnt_q + `RPF_WARN_CNT_W'(1);
    end
    if (wcnt_d == `RPF_WARN_CNT_W'(`RPF_WARN_RUN) && wcnt_q != wcnt_d)
      warn_d = 1'b1;
    else if (warning_read)
      warn_d = 1'b0;
  end

  always_comb
  begin
    irq_d = |(flt_q & fault_unmask_bit) |
            (warn_q & ~current_warning_mask);
  end

  // straps caught once after reset release
  always_comb
  begin
    strap_d      = strap_q;
    strap_done_d = 1'b1;
    if (!strap_done_q)
      strap_d = {strap_bb_ov, strap_bb_freq, strap_remote_sense,
                 strap_dual_34, strap_dual_12};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stat_q       <= '1;
      flt_q        <= '0;
      wcnt_q       <= '0;
      warn_q       <= 1'b0;
      irq_q        <= 1'b0;
      strap_q      <= '0;
      strap_done_q <= 1'b0;
    end
    else
    begin
      stat_q       <= stat_d;
      flt_q        <= flt_d;
      wcnt_q       <= wcnt_d;
      warn_q       <= warn_d;
      irq_q        <= irq_d;
      strap_q      <= strap_d;
      strap_done_q <= strap_done_d;
    end
  end

  assign power_good_status    = stat_q;
  assign power_good_live      = pg_sync;
  assign interrupt_out_low    = ~irq_q;
  assign current_warning_flag = warn_q;
  assign dual_12              = strap_q[0];
  assign dual_34              = strap_q[1];
  assign remote_sense_select  = strap_q[2];
  assign feedback_two_is_gnd  = strap_q[2];
  assign feedback_four_is_gnd = strap_q[2];
  assign bb_freq_high         = strap_q[3];
  assign bb_ov_high           = strap_q[4];
  // second phase of a pair runs half a period late
  assign phase_invert = {strap_q[1], 1'b0, strap_q[0], 1'b0};

  always_comb
  begin
    vset_eff[0] = vset_reg[0];
    vset_eff[1] = strap_q[0] ? vset_reg[0] : vset_reg[1];
    vset_eff[2] = vset_reg[2];
    vset_eff[3] = strap_q[1] ? vset_reg[2] : vset_reg[3];
  end

  // fault on an enabled regulator shows as status 0 within three cycles
  sequence s_fault_seen;
    regulator_on[0] && !pgood_comp_in[0];
  endsequence

  stat_drop_a: assert property (@(posedge clk) disable iff (reset)
    s_fault_seen ##1 regulator_on[0] && !pgood_comp_in[0] ##1 regulator_on[0]
      |-> ##1 !power_good_status[0])
    else $error("status did not drop on fault");

  mask_hold_a: assert property (@(posedge clk) disable iff (reset)
    ((flt_q & fault_unmask_bit) == '0 && !(warn_q && !current_warning_mask))
      |=> interrupt_out_low)
    else $error("masked fault raised interrupt");

  irq_fire_a: assert property (@(posedge clk) disable iff (reset)
    (flt_q[0] && fault_unmask_bit[0]) |=> !interrupt_out_low)
    else $error("unmasked fault did not pull pin low");

  irq_keep_a: assert property (@(posedge clk) disable iff (reset)
    (flt_q[0] && regulator_on[0] && !status_read[0]) |=> flt_q[0])
    else $error("fault cleared without read or off");

  latch_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!stat_q[0] && regulator_on[0] && !status_read[0]) |=> !power_good_status[0])
    else $error("status released without read");

  live_route_a: assert property (@(posedge clk) disable iff (reset)
    $rose(pgood_comp_in[1]) |-> ##2 power_good_live[1])
    else $error("live power-good not synchronised in two cycles");

  pair_set_a: assert property (@(posedge clk) disable iff (reset)
    dual_12 |-> vset_eff[1] == vset_reg[0])
    else $error("pair not using converter one settings");

  strap_fix_a: assert property (@(posedge clk) disable iff (reset)
    strap_done_q |=> $stable(strap_q))
    else $error("factory setting changed at run time");

  warn_set_a: assert property (@(posedge clk) disable iff (reset)
    (wcnt_q == 5'd15 && sw_cycle_tick && peak_over_warn) |=> current_warning_flag)
    else $error("warning flag not set after run");

  or_irq_a: assert property (@(posedge clk) disable iff (reset)
    (|(flt_q & fault_unmask_bit)) |=> !interrupt_out_low)
    else $error("combined fault did not assert pin");
endmodule : rpf_top
`default_nettype wire

// ===== shared/rpf_defs.svh
// Purpose: constants for the regulator power-good / fault interrupt block
// Assumes: 200 MHz system clock
// Notes: factory settings are captured from straps after reset release
`ifndef RPF_DEFS_SVH
`define RPF_DEFS_SVH
`define RPF_NUM_REG        6
`define RPF_WARN_RUN       16
`define RPF_WARN_CNT_W     5
`define RPF_PHASE_FREQ_LO  1'b0
`define RPF_OV_THRESH_LO   1'b0
`define RPF_UNMASK_RESET   6'h3f
`endif

// ===== shared/rpf_pkg.sv
// Purpose: types for the regulator power-good / fault interrupt block
// Assumes: nothing beyond the defs header
// Notes: index 0..3 are the four bucks, 4 the small buck, 5 the buck-boost
`include "rpf_defs.svh"
package rpf_pkg;
  typedef logic [`RPF_NUM_REG-1:0] rpf_vec_t;
  typedef enum logic [1:0] {RPF_BB_FREQ_LOW, RPF_BB_FREQ_HIGH} rpf_bb_freq_t;
endpackage : rpf_pkg

// ===== testbench/rpf_host_model.sv
// Purpose: host side, reads status bits after a chosen lag
// Assumes: go is a one-cycle pulse
// Notes: lag 0 answers on the next edge
`timescale 1ns/1ps
`default_nettype none
module rpf_host_model
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [5:0] sel,
  input  wire logic [3:0] lag,
  output logic      [5:0] status_read
);
  initial status_read = 6'h00;
  always @(posedge clk)
  begin
    if (go)
    begin
      repeat (lag) @(posedge clk);
      status_read <= sel;
      @(posedge clk);
      status_read <= 6'h00;
    end
  end
endmodule : rpf_host_model
`default_nettype wire

// ===== testbench/test_rpf_top.sv
// Purpose: self-checking bench for the power-good interrupt block
// Assumes: inputs move 1 ns after the rising edge
// Notes: straps are random and captured once
`timescale 1ns/1ps
`default_nettype none
module test_rpf_top;
  import rpf_pkg::*;
  logic       clk, reset, tick, peak, wmask, wread, go;
  logic       s12, s34, srs, sfq, sov, irq_n, wflag;
  logic       d12, d34, rss, fb2, fb4, bfh, boh;
  logic [5:0] pgc, on, unm, rd, pgs, pgl, sel;
  logic [4:0] st5;
  logic [3:0] lag, pinv;
  logic [7:0] vreg [0:3];
  logic [7:0] veff [0:3];
  int         failures, tests_run, cycles, r;
  rpf_host_model rpf_host_model_inst (.clk(clk), .go(go), .sel(sel), .lag(lag), .status_read(rd));
  rpf_top rpf_top_inst (.clk(clk), .reset(reset), .pgood_comp_in(pgc), .regulator_on(on),
    .fault_unmask_bit(unm), .status_read(rd), .sw_cycle_tick(tick), .peak_over_warn(peak),
    .current_warning_mask(wmask), .warning_read(wread), .strap_dual_12(s12),
    .strap_dual_34(s34), .strap_remote_sense(srs), .strap_bb_freq(sfq), .strap_bb_ov(sov),
    .vset_reg(vreg), .power_good_status(pgs), .power_good_live(pgl),
    .interrupt_out_low(irq_n), .current_warning_flag(wflag), .dual_12(d12), .dual_34(d34),
    .remote_sense_select(rss), .feedback_two_is_gnd(fb2), .feedback_four_is_gnd(fb4),
    .bb_freq_high(bfh), .bb_ov_high(boh), .phase_invert(pinv), .vset_eff(veff));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic host_read(input int n, input logic [3:0] l);
    sel = 6'h01 << n;
    lag = l;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(l + 3);
  endtask : host_read
  task automatic fault_case(input int n, input logic m, input logic [3:0] l);
    unm = 6'h3f;
    unm[n] = m;
    pgc[n] = 1'b0;
    cyc(6);
    chk({pgs[n], pgl[n]}, 2'b00);
    chk(irq_n, {~m});
    host_read(n, l);
    chk({pgs[n], irq_n}, {1'b0, ~m});
    pgc[n] = 1'b1;
    cyc(4);
    chk({pgs[n], pgl[n]}, 2'b01);
    host_read(n, l);
    chk({pgs[n], irq_n}, 2'b11);
    $display("fault test done, regulator %0d", n);
  endtask : fault_case
  task automatic warn_run(input logic m);
    wmask = m;
    peak = 1'b0;
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    peak = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      if (k == 15)
        chk(wflag, 1'b0);
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
    end
    cyc(1);
    chk({wflag, irq_n}, {1'b1, m});
    wread = 1'b1;
    cyc(1);
    wread = 1'b0;
    cyc(2);
    chk({wflag, irq_n}, 2'b01);
    $display("warning test done, mask %0d", m);
  endtask : warn_run
  initial
  begin
    void'($urandom(32'h1d798337));
    {reset, tick, peak, wmask, wread, go} = 6'h20;
    {pgc, on, unm, sel, lag} = 28'hfffffff;
    {s12, s34, srs, sfq, sov} = 5'($urandom());
    for (int k = 0; k < 4; k++)
      vreg[k] = 8'($urandom());
    cyc(5);
    chk({pgs, irq_n}, 7'h7f);
    reset = 1'b0;
    cyc(3);
    st5 = {s12, s34, srs, sfq, sov};
    chk({d12, d34, rss, bfh, boh}, st5);
    chk({fb2, fb4, pinv}, {srs, srs, s34, 1'b0, s12, 1'b0});
    chk({veff[1], veff[3]}, {s12 ? vreg[0] : vreg[1], s34 ? vreg[2] : vreg[3]});
    chk({veff[0], veff[2]}, {vreg[0], vreg[2]});
    {s12, s34, srs, sfq, sov} = ~st5;
    cyc(3);
    chk({d12, d34, rss, bfh, boh}, st5);
    $display("strap test done");
    for (r = 0; r < 6; r++)
      fault_case(r, 1'($urandom()), 4'($urandom_range(3, 0)));
    // all unmasked, so the surviving fault alone must hold the pin
    unm = 6'h3f;
    r = $urandom_range(5, 0);
    pgc[r] = 1'b0;
    pgc[(r + 1) % 6] = 1'b0;
    cyc(6);
    on[r] = 1'b0;
    cyc(4);
    chk({pgs[r], irq_n}, 2'b10);
    on[(r + 1) % 6] = 1'b0;
    cyc(4);
    chk(irq_n, 1'b1);
    // outputs back in regulation before the enables, else a new fault latches
    pgc = 6'h3f;
    cyc(3);
    on = 6'h3f;
    cyc(6);
    chk({pgs, irq_n}, 7'h7f);
    $display("switch-off test done");
    warn_run(1'b0);
    warn_run(1'b1);
    end_sim();
  end
endmodule : test_rpf_top
`default_nettype wire
